//--- hw/lps_ctrl.sv
// Low-power state control: standby, stop clock and suspend sequencing.
// Assumes the power manager holds suspend_req stable while suspended.
`timescale 1ns/10ps

// Summary of operation
// R01: Five low-power states are supported
// R02: Standby needs all five idle conditions
// R03: Standby entry uses no timer
// R04: Standby exits at once on access
// R05: Stop clock: arbiter off, suspend refresh
// R06: On-suspend refreshes DRAM from suspend clock
// R07: On-suspend keeps planes powered, clocks stopped
// R08: RAM suspend isolates CPU, L2, PCI
// R09: RAM suspend exit resets core well
// R10: Disk suspend and soft-off power off
// R11: Manager state selects device state
// R12: PCI reset resets the core logic
// R13: Refresh and sequencing logic not reset
// R14: Controller flushes DRAM cache before suspend; lps_ctrl has no cache logic, lps_pm only delays entry
// R15: Controller reinitializes DRAM cache after resume; lps_ctrl has no cache logic, lps_pm only delays exit
// R16: Encoded state readable, changed on events
module lps_ctrl (
  // Clock and reset
  input  wire logic                 mclk,
  input  wire logic                 rstn,
  input  wire logic                 pci_rstn,
  // Idle and mode inputs
  input  wire logic                 host_idle,
  input  wire logic                 pci_idle,
  input  wire logic                 test_mode,
  input  wire logic                 internal_idle,
  // New accesses
  input  wire logic                 cpu_access,
  input  wire logic                 pci_master_access,
  // Stop clock and suspend requests
  input  wire logic                 stop_clock_request,
  input  wire logic [2:0]           suspend_req,
  input  wire logic                 suspend_clock,
  // State and controls
  output lps_pkg::lps_state_type    lp_state,
  output logic                      arbiter_disable,
  output logic                      suspend_refresh,
  output logic                      refresh_pulse,
  output logic                      clocks_stop,
  output logic                      iface_isolate,
  output logic                      power_off,
  output logic                      core_reset_n,
  output logic                      exit_late
);

  lps_pkg::lps_state_type state_r;
  lps_pkg::lps_state_type state_nxt;
  logic [21:0]            lat_r;
  logic [21:0]            lat_nxt;
  logic                   core_rst_r;
  logic                   core_rst_nxt;
  logic                   late_r;
  logic                   late_nxt;
  logic                   standby_ok;
  logic                   access;
  logic                   core_rstn;
  logic                   lat_run;
  logic                   arb_off_r;
  logic                   arb_off_nxt;
  logic                   refresh_on_r;
  logic                   refresh_on_nxt;
  logic                   clk_stop_r;
  logic                   clk_stop_nxt;
  logic                   isolate_r;
  logic                   isolate_nxt;
  logic                   pwr_off_r;
  logic                   pwr_off_nxt;

  //////////////////////////////////////////////////////////////////////////////
  // Core reset follows PCI reset or a RAM-suspend exit
  assign core_rstn = rstn & pci_rstn & core_rst_r;  // see R12

  assign standby_ok = host_idle & pci_idle & ~test_mode & internal_idle & core_rstn;  // see R02
  assign access     = cpu_access | pci_master_access;

  //////////////////////////////////////////////////////////////////////////////
  // State sequencing
  always_comb begin
    state_nxt    = state_r;
    core_rst_nxt = 1'b1;
    case (state_r)
      lps_pkg::LPS_ACTIVE: begin
        if (suspend_req == lps_pkg::LPS_REQ_ON_SUSP) begin
          state_nxt = lps_pkg::LPS_ON_SUSPEND;  // see R11
        end else if (suspend_req == lps_pkg::LPS_REQ_RAM_SUSP) begin
          state_nxt = lps_pkg::LPS_OFF_SUSPEND;  // see R11
        end else if (suspend_req == lps_pkg::LPS_REQ_DISK
                     || suspend_req == lps_pkg::LPS_REQ_SOFT_OFF) begin
          state_nxt = lps_pkg::LPS_POWER_OFF;  // see R10
        end else if (stop_clock_request) begin
          state_nxt = lps_pkg::LPS_STOPCLK;  // see R05
        end else if (standby_ok && !access) begin
          state_nxt = lps_pkg::LPS_STANDBY;  // see R03
        end
      end
      lps_pkg::LPS_STANDBY: begin
        if (access || !standby_ok || stop_clock_request
            || suspend_req != lps_pkg::LPS_REQ_NONE) begin
          state_nxt = lps_pkg::LPS_ACTIVE;
        end
      end
      lps_pkg::LPS_STOPCLK: begin
        if (!stop_clock_request) begin
          state_nxt = lps_pkg::LPS_ACTIVE;
        end
      end
      lps_pkg::LPS_ON_SUSPEND: begin
        if (suspend_req != lps_pkg::LPS_REQ_ON_SUSP) begin
          state_nxt = lps_pkg::LPS_ACTIVE;
        end
      end
      lps_pkg::LPS_OFF_SUSPEND: begin
        if (suspend_req != lps_pkg::LPS_REQ_RAM_SUSP) begin
          state_nxt    = lps_pkg::LPS_ACTIVE;
          core_rst_nxt = 1'b0;  // see R09
        end
      end
      lps_pkg::LPS_POWER_OFF: begin
        if (suspend_req == lps_pkg::LPS_REQ_NONE) begin
          state_nxt = lps_pkg::LPS_ACTIVE;
        end
      end
      default: state_nxt = lps_pkg::LPS_ACTIVE;
    endcase
  end

  // Sequencing lives in the resume well: only the power-up reset clears it
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      state_r    <= lps_pkg::LPS_ACTIVE;
      core_rst_r <= 1'b1;
    end else begin
      state_r    <= state_nxt;  // see R16
      core_rst_r <= core_rst_nxt;  // see R13
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Exit latency watch for stop clock and on-suspend
  // Only these two carry the short exit target; the counter saturates
  assign lat_run = (state_r == lps_pkg::LPS_STOPCLK)
                 | (state_r == lps_pkg::LPS_ON_SUSPEND);

  always_comb begin
    lat_nxt  = 22'h000000;
    late_nxt = late_r;
    if (state_r == lps_pkg::LPS_ACTIVE) begin
      late_nxt = 1'b0;
    end
    if (lat_run && state_nxt == lps_pkg::LPS_ACTIVE) begin
      lat_nxt = 22'h000000;
      if (lat_r > 22'(lps_pkg::LPS_EXIT_CYC)) begin
        late_nxt = 1'b1;  // see R05
      end
    end else if (lat_run && !(&lat_r)) begin
      lat_nxt = lat_r + 22'h000001;
    end else if (lat_run) begin
      lat_nxt = lat_r;
    end
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      lat_r  <= 22'h000000;
      late_r <= 1'b0;
    end else begin
      lat_r  <= lat_nxt;
      late_r <= late_nxt;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Outputs, registered off the next state so they switch with lp_state
  always_comb begin
    arb_off_nxt    = (state_nxt == lps_pkg::LPS_STOPCLK);  // see R05
    refresh_on_nxt = (state_nxt == lps_pkg::LPS_STOPCLK)
                   | (state_nxt == lps_pkg::LPS_ON_SUSPEND)   // see R06
                   | (state_nxt == lps_pkg::LPS_OFF_SUSPEND); // see R08
    clk_stop_nxt   = (state_nxt == lps_pkg::LPS_ON_SUSPEND)   // see R07
                   | (state_nxt == lps_pkg::LPS_OFF_SUSPEND);
    isolate_nxt    = (state_nxt == lps_pkg::LPS_OFF_SUSPEND)  // see R08
                   | (state_nxt == lps_pkg::LPS_POWER_OFF);
    pwr_off_nxt    = (state_nxt == lps_pkg::LPS_POWER_OFF);   // see R10
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      arb_off_r    <= 1'b0;
      refresh_on_r <= 1'b0;
      clk_stop_r   <= 1'b0;
      isolate_r    <= 1'b0;
      pwr_off_r    <= 1'b0;
    end else begin
      arb_off_r    <= arb_off_nxt;
      refresh_on_r <= refresh_on_nxt;
      clk_stop_r   <= clk_stop_nxt;
      isolate_r    <= isolate_nxt;
      pwr_off_r    <= pwr_off_nxt;
    end
  end

  assign arbiter_disable = arb_off_r;
  assign suspend_refresh = refresh_on_r;
  assign clocks_stop     = clk_stop_r;
  assign iface_isolate   = isolate_r;
  assign power_off       = pwr_off_r;
  assign lp_state     = state_r;  // see R01
  assign core_reset_n = core_rstn;
  assign exit_late    = late_r;

  lps_refresh #(
    .REF_DIV       (lps_pkg::LPS_REF_DIV)
  ) u_refresh (
    .mclk          (mclk),
    .enable        (suspend_refresh & ~power_off),
    .suspend_clock (suspend_clock),
    .refresh_pulse (refresh_pulse)
  );

endmodule : lps_ctrl

//--- hw/lps_pkg.sv
// Package for the low-power state control block: states, requests, timing.
// Assumes a single 40 MHz core clock; suspend clock arrives as a sampled level.
package lps_pkg;

  // Device low-power states, readable by other units
  typedef enum logic [2:0] {
    LPS_ACTIVE,
    LPS_STANDBY,
    LPS_STOPCLK,
    LPS_ON_SUSPEND,
    LPS_OFF_SUSPEND,
    LPS_POWER_OFF
  } lps_state_type;

  // System suspend request codes from the power manager
  localparam logic [2:0] LPS_REQ_NONE     = 3'h0;
  localparam logic [2:0] LPS_REQ_ON_SUSP  = 3'h1;
  localparam logic [2:0] LPS_REQ_RAM_SUSP = 3'h2;
  localparam logic [2:0] LPS_REQ_DISK     = 3'h3;
  localparam logic [2:0] LPS_REQ_SOFT_OFF = 3'h4;

  // Clock rate and exit-latency budget
  localparam int          LPS_CLK_HZ      = 40000000;
  localparam int          LPS_EXIT_MS     = 10;
  localparam int          LPS_EXIT_CYC    = (LPS_CLK_HZ / 1000) * LPS_EXIT_MS - 1;

  // Suspend-clock cycles between refresh requests
  localparam int          LPS_REF_DIV     = 4;

endpackage : lps_pkg

//--- hw/lps_refresh.sv
// Resume-well refresh pacer: issues DRAM refresh pulses off the suspend clock.
// Assumes suspend_clock is a level synchronous to mclk; this logic is never reset.
`timescale 1ns/10ps
module lps_refresh #(
  parameter int REF_DIV = lps_pkg::LPS_REF_DIV
) (
  // Clock
  input  wire logic mclk,
  // Control
  input  wire logic enable,
  input  wire logic suspend_clock,
  // Result
  output logic      refresh_pulse
);

  logic [7:0] div_r;
  logic [7:0] div_nxt;
  logic       sclk_r;
  logic       sclk_nxt;
  logic       pulse_r;
  logic       pulse_nxt;
  logic       rise;

  assign rise = suspend_clock & ~sclk_r;

  always_comb begin
    sclk_nxt  = suspend_clock;
    div_nxt   = div_r;
    pulse_nxt = 1'b0;
    if (!enable) begin
      div_nxt = 8'h00;
    end else if (rise) begin
      if (div_r == 8'(REF_DIV - 1)) begin
        div_nxt   = 8'h00;
        pulse_nxt = 1'b1;
      end else begin
        div_nxt = div_r + 8'h01;
      end
    end
  end

  // Resume well: free-running, not cleared by core reset  // see R13
  always_ff @(posedge mclk) begin
    sclk_r  <= sclk_nxt;
    div_r   <= div_nxt;
    pulse_r <= pulse_nxt;
  end

  assign refresh_pulse = pulse_r;

endmodule : lps_refresh

//--- sim/lps_ctrl_chk.sv
// Checker for lps_ctrl: state entry, decoded outputs, core reset.
// Assumes a single mclk domain; bound to every lps_ctrl.
`timescale 1ns/10ps
module lps_ctrl_chk (
  // Clock and resets
  input wire logic mclk, rstn, pci_rstn,
  // Conditions and requests
  input wire logic host_idle, pci_idle, test_mode, internal_idle,
  input wire logic cpu_access, pci_master_access, stop_clock_request,
  input wire logic [2:0] suspend_req,
  // Watched outputs
  input wire lps_pkg::lps_state_type lp_state,
  input wire logic arbiter_disable, suspend_refresh, clocks_stop,
  input wire logic iface_isolate, power_off, core_reset_n
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!rstn);
  wire logic act = (lp_state == lps_pkg::LPS_ACTIVE);
  wire logic idle = host_idle & pci_idle & internal_idle & ~test_mode;
  wire logic quiet = idle & core_reset_n & ~cpu_access & ~pci_master_access
    & ~stop_clock_request & (suspend_req == 3'h0);
  ////////////////////////////////////////
  stby_entry_a: assert property (act && quiet |=> lp_state == lps_pkg::LPS_STANDBY)
    else $error("standby not entered");
  stby_guard_a: assert property (act && !(idle && core_reset_n)
    |=> lp_state != lps_pkg::LPS_STANDBY) else $error("standby entered while busy");
  stby_exit_a: assert property (lp_state == lps_pkg::LPS_STANDBY && (cpu_access || pci_master_access)
    |=> act) else $error("standby exit late");
  stop_entry_a: assert property (act && stop_clock_request && suspend_req == 3'h0
    |=> lp_state == lps_pkg::LPS_STOPCLK && arbiter_disable && suspend_refresh)
    else $error("stop clock entry");
  on_susp_a: assert property (act && suspend_req == 3'h1 |=> lp_state == lps_pkg::LPS_ON_SUSPEND
    && clocks_stop && suspend_refresh && !iface_isolate && !power_off) else $error("on suspend");
  ram_susp_a: assert property (act && suspend_req == 3'h2 |=> lp_state == lps_pkg::LPS_OFF_SUSPEND
    && iface_isolate && suspend_refresh && !power_off) else $error("ram suspend");
  off_state_a: assert property (act && (suspend_req == 3'h3 || suspend_req == 3'h4)
    |=> lp_state == lps_pkg::LPS_POWER_OFF && power_off) else $error("power off");
  ram_exit_a: assert property (lp_state == lps_pkg::LPS_OFF_SUSPEND ##1 act
    |-> !core_reset_n ##1 (core_reset_n || !pci_rstn)) else $error("resume reset");
  pci_rst_a: assert property (!pci_rstn |-> !core_reset_n)
    else $error("core reset misses pci reset");
endmodule : lps_ctrl_chk

bind lps_ctrl lps_ctrl_chk u_chk (.mclk, .rstn, .pci_rstn, .host_idle, .pci_idle,
  .test_mode, .internal_idle, .cpu_access, .pci_master_access, .stop_clock_request,
  .suspend_req, .lp_state, .arbiter_disable, .suspend_refresh, .clocks_stop,
  .iface_isolate, .power_off, .core_reset_n);

//--- sim/lps_pm.sv
// Power manager model: system suspend state and free-running suspend clock.
// Assumes the bench names the wanted state; cache work fills the delay.
`timescale 1ns/10ps
module lps_pm #(
  parameter int FLUSH = 3
) (
  // Clock
  input wire logic mclk,
  // Wanted system state
  input wire logic [2:0] want,
  // Toward the block
  output logic [2:0] suspend_req,
  output logic suspend_clock
);
  int cnt = 0;
  int div = 0;
  initial suspend_req = 3'h0;
  initial suspend_clock = 1'b0;
  always @(negedge mclk) begin
    div = (div + 1) % 3;
    if (div == 0) suspend_clock <= ~suspend_clock;
    cnt = (want == suspend_req) ? 0 : cnt + 1;
    // Flush before entry, reinit after exit
    if (cnt > FLUSH) suspend_req <= want;
  end
endmodule : lps_pm

//--- sim/test_lps_ctrl.sv
// Bench for lps_ctrl: standby, stop clock, suspend states, resets.
// Assumes lps_pm drives suspend_req and suspend_clock.
`timescale 1ns/10ps
module test_lps_ctrl;
  logic mclk = 1'b0, rstn = 1'b0, pci_rstn = 1'b1, test_mode = 1'b0;
  logic host_idle = 1'b0, pci_idle = 1'b0, internal_idle = 1'b0;
  logic cpu_access = 1'b0, pci_master_access = 1'b0, stop_clock_request = 1'b0;
  logic [2:0] want = 3'h0, suspend_req;
  logic suspend_clock, arbiter_disable, suspend_refresh, refresh_pulse, clocks_stop;
  logic iface_isolate, power_off, core_reset_n, exit_late;
  lps_pkg::lps_state_type lp_state;
  int num_errors = 0, n_tests = 0, cycles = 0;
  always #12.5 mclk = ~mclk;
  lps_pm u_pm (.mclk, .want, .suspend_req, .suspend_clock);
  lps_ctrl u_dut (.mclk, .rstn, .pci_rstn, .host_idle, .pci_idle, .test_mode,
    .internal_idle, .cpu_access, .pci_master_access, .stop_clock_request, .suspend_req,
    .suspend_clock, .lp_state, .arbiter_disable, .suspend_refresh, .refresh_pulse,
    .clocks_stop, .iface_isolate, .power_off, .core_reset_n, .exit_late);
  ////////////////////////////////////////
  task automatic check(input string what, input logic [3:0] exp, input logic [3:0] got);
    n_tests++;
    if (got !== exp) begin
      num_errors++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask : check
  task automatic final_report();
    $display("errors %0d checks %0d", num_errors, n_tests);
    if (num_errors == 0 && n_tests > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : final_report
  always @(posedge mclk) begin
    cycles++;
    if (cycles == 2000) begin
      num_errors++;
      final_report();
    end
  end
  ////////////////////////////////////////
  task automatic t_standby();
    {host_idle, pci_idle, internal_idle, pci_rstn} = 4'hE;
    repeat (2) @(negedge mclk);
    check("core reset", lps_pkg::LPS_ACTIVE, lp_state);
    check("core reset n", 4'h0, core_reset_n);
    {pci_rstn, test_mode} = 2'h3;
    repeat (3) @(negedge mclk);
    check("test mode", lps_pkg::LPS_ACTIVE, lp_state);
    test_mode = 1'b0;
    @(negedge mclk);
    check("standby", lps_pkg::LPS_STANDBY, lp_state);
    cpu_access = 1'b1;
    @(negedge mclk);
    check("cpu wake", lps_pkg::LPS_ACTIVE, lp_state);
    cpu_access = 1'b0;
    @(negedge mclk);
    pci_master_access = 1'b1;
    @(negedge mclk);
    check("pci wake", lps_pkg::LPS_ACTIVE, lp_state);
    pci_master_access = 1'b0;
    for (int i = 0; i < 3; i++) begin
      {host_idle, pci_idle, internal_idle} = 3'h7 ^ (3'h1 << i);
      repeat (2) @(negedge mclk);
      check("busy hold", lps_pkg::LPS_ACTIVE, lp_state);
    end
  endtask : t_standby
  task automatic t_stop();
    stop_clock_request = 1'b1;
    @(negedge mclk);
    check("stop", lps_pkg::LPS_STOPCLK, lp_state);
    check("arbiter off", 4'h1, arbiter_disable);
    stop_clock_request = 1'b0;
    @(negedge mclk);
    check("stop exit", lps_pkg::LPS_ACTIVE, lp_state);
    check("exit late", 4'h0, exit_late);
  endtask : t_stop
  task automatic t_suspend(input logic [2:0] req, input logic [3:0] st, input logic [2:0] outs);
    int pulses;
    int low;
    pulses = 0;
    low = 0;
    want = req;
    pci_rstn = (req != 3'h2);
    repeat (60) begin
      @(negedge mclk);
      if (refresh_pulse === 1'b1) pulses++;
    end
    check("suspend state", st, lp_state);
    check("stop iso off", outs, {clocks_stop, iface_isolate, power_off});
    check("refresh", req < 3'h3, pulses > 0);
    pci_rstn = 1'b1;
    want = 3'h0;
    repeat (20) begin
      @(negedge mclk);
      if (core_reset_n === 1'b0) low++;
    end
    check("resumed", lps_pkg::LPS_ACTIVE, lp_state);
    if (req < 3'h3) check("resume reset", req == 3'h2, low);
  endtask : t_suspend
  initial begin
    repeat (12) @(negedge mclk);
    rstn = 1'b1;
    @(negedge mclk);
    t_standby();
    t_stop();
    t_suspend(3'h1, lps_pkg::LPS_ON_SUSPEND, 3'h4);
    t_suspend(3'h2, lps_pkg::LPS_OFF_SUSPEND, 3'h6);
    t_suspend(3'h3, lps_pkg::LPS_POWER_OFF, 3'h3);
    t_suspend(3'h4, lps_pkg::LPS_POWER_OFF, 3'h3);
    final_report();
  end
endmodule : test_lps_ctrl
